// ---- bench/dbws_port_test.sv ----
`timescale 1ns/100ps

module dbws_port_test;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wu, wl, ri, wi, fc, doe, davail, oe;
  logic [15:0] addr, dline, dout, rd;
  int n_fail = 0;
  int n_checks = 0;
  int lat;

  // 25 MHz
  always #20 clk_in = ~clk_in;

  dbws_port DUT (.clk_in(clk_in), .resetn_in(resetn_in), .write_upper_in(wu),
    .write_lower_in(wl), .read_initiate_in(ri), .write_initiate_in(wi), .full_cycle_in(fc),
    .addr_in(addr), .data_in(dline), .data_out(dout), .data_oe_out(doe),
    .data_avail_out(davail));

  dbws_requestor req (.clk_in(clk_in), .data_avail_in(davail), .data_oe_in(doe),
    .data_dev_in(dout), .write_upper_out(wu), .write_lower_out(wl), .read_initiate_out(ri),
    .write_initiate_out(wi), .full_cycle_out(fc), .addr_out(addr), .data_line_out(dline));

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a lost ack ends the run, nothing after it can be trusted
  task automatic chk_lat(input int got, input int exp);
    chk(16'(got), 16'(exp));
    if (got >= 12 && exp < 12) stop_test();
  endtask

  task automatic wr(input logic up, input logic lo, input logic [15:0] a, input logic [15:0] d);
    req.op(up, lo, 1'b1, 1'b0, a, d, 0, rd, oe, lat);
    chk_lat(lat, 4);
    chk(16'(oe), 16'h0000);
  endtask

  task automatic rdw(input logic [15:0] a, input logic [15:0] exp);
    req.op(1'b0, 1'b0, 1'b1, 1'b0, a, 16'h0000, 0, rd, oe, lat);
    chk_lat(lat, 5);
    chk(16'(oe), 16'h0001);
    chk(rd, exp);
  endtask

  task automatic t_word;
    wr(1'b1, 1'b1, 16'h0010, 16'h1234);
    rdw(16'h0010, 16'h1234);
  endtask

  task automatic t_lanes;
    wr(1'b1, 1'b1, 16'h0020, 16'ha5a5);
    wr(1'b1, 1'b0, 16'h0020, 16'h3cc3);
    rdw(16'h0020, 16'h3ca5);
    wr(1'b0, 1'b1, 16'h0020, 16'h0f0f);
    rdw(16'h0020, 16'h3c0f);
  endtask

  task automatic t_edges;
    wr(1'b1, 1'b1, 16'hffff, 16'hbeef);
    wr(1'b1, 1'b1, 16'h0000, 16'hcafe);
    rdw(16'hffff, 16'hbeef);
    rdw(16'h0000, 16'hcafe);
  endtask

  task automatic t_rmw;
    wr(1'b1, 1'b1, 16'h0030, 16'h1111);
    req.op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0030, 16'h0000, 0, rd, oe, lat);
    chk_lat(lat, 5);
    chk(rd, 16'h1111);
    req.op(1'b1, 1'b0, 1'b0, 1'b1, 16'h0030, 16'h2222, 0, rd, oe, lat);
    chk_lat(lat, 4);
    req.op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0030, 16'h0000, 0, rd, oe, lat);
    chk_lat(lat, 5);
    chk(rd, 16'h2211);
    // write half with no lane selected still acknowledges but stores nothing
    req.op(1'b0, 1'b0, 1'b0, 1'b1, 16'h0030, 16'hffff, 0, rd, oe, lat);
    chk_lat(lat, 4);
    rdw(16'h0030, 16'h2211);
    // rmw write half with both selects covers the whole word
    req.op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0030, 16'h0000, 0, rd, oe, lat);
    chk_lat(lat, 5);
    chk(rd, 16'h2211);
    req.op(1'b1, 1'b1, 1'b0, 1'b1, 16'h0030, 16'h3333, 0, rd, oe, lat);
    chk_lat(lat, 4);
    rdw(16'h0030, 16'h3333);
  endtask

  task automatic t_slow;
    wr(1'b1, 1'b1, 16'h0040, 16'h0000);
    req.op(1'b0, 1'b1, 1'b1, 1'b0, 16'h0040, 16'h5678, 6, rd, oe, lat);
    chk_lat(lat, 4);
    req.op(1'b0, 1'b0, 1'b1, 1'b0, 16'h0040, 16'h0000, 6, rd, oe, lat);
    chk_lat(lat, 5);
    chk(rd, 16'h0078);
  endtask

  // write initiate in a read-write cycle is not an operation: no ack, memory untouched
  task automatic t_refuse;
    wr(1'b1, 1'b1, 16'h0050, 16'h4444);
    req.op(1'b1, 1'b1, 1'b1, 1'b1, 16'h0050, 16'h9999, 0, rd, oe, lat);
    chk_lat(lat, 12);
    rdw(16'h0050, 16'h4444);
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    chk(16'(davail), 16'h0000);
    chk(16'(doe), 16'h0000);
    chk(dout, 16'h0000);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_word();
    t_lanes();
    t_edges();
    t_rmw();
    t_slow();
    t_refuse();
    stop_test();
  end
endmodule

// ---- bench/dbws_requestor.sv ----
`timescale 1ns/100ps

// requestor side of the memory port; all lines change only right at a rising edge
module dbws_requestor (
  input wire logic clk_in,
  input wire logic data_avail_in,
  input wire logic data_oe_in,
  input wire logic [15:0] data_dev_in,
  output logic write_upper_out = 1'b0,
  output logic write_lower_out = 1'b0,
  output logic read_initiate_out = 1'b0,
  output logic write_initiate_out = 1'b0,
  output logic full_cycle_out = 1'b0,
  output logic [15:0] addr_out = 16'h0000,
  output logic [15:0] data_line_out
);
  logic [15:0] drv_r = 16'h0000;
  logic drv_en_r = 1'b0;

  // wire level; once released, the lines show the inverse of their last value
  // rather than a stale copy that a broken read could pass on
  assign data_line_out = data_oe_in ? data_dev_in : (drv_en_r ? drv_r : ~drv_r);

  // one operation; lat counts edges from initiate up until the ack is seen, 99 if it never drops
  task automatic op(input logic up, input logic lo, input logic full, input logic second,
                    input logic [15:0] a, input logic [15:0] d, input int hold,
                    output logic [15:0] rd, output logic oe, output int lat);
    int n;
    @(posedge clk_in);
    write_upper_out <= up;
    write_lower_out <= lo;
    full_cycle_out <= full;
    addr_out <= a;
    drv_r <= d;
    drv_en_r <= up | lo;
    // selects settle through the synchroniser before initiate goes up
    repeat (2) @(posedge clk_in);
    if (second) begin
      write_initiate_out <= 1'b1;
    end else begin
      read_initiate_out <= 1'b1;
    end
    lat = 0;
    do begin
      @(posedge clk_in);
      lat++;
    end while (data_avail_in !== 1'b1 && lat < 12);
    rd = data_line_out;
    oe = data_oe_in;
    // a slow requestor keeps initiate up after the ack
    repeat (hold) @(posedge clk_in);
    read_initiate_out <= 1'b0;
    write_initiate_out <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (data_avail_in !== 1'b0 && n < 12);
    if (n >= 12) begin
      lat = 99;
    end
    write_upper_out <= 1'b0;
    write_lower_out <= 1'b0;
    drv_en_r <= 1'b0;
  endtask
endmodule

// ---- rtl/dbws_mem.sv ----
`timescale 1ns/100ps
`include "dbws_regs.svh"

// word store with per-byte write enables and a registered full-word read
module dbws_mem (
  input wire logic clk_in,
  input wire logic [`DBWS_ADDR_W-1:0] addr_in,
  input wire logic [`DBWS_DATA_W-1:0] wdata_in,
  input wire logic [1:0] lane_we_in,
  input wire logic rd_en_in,
  output logic [`DBWS_DATA_W-1:0] rdata_out
);
  logic [`DBWS_DATA_W-1:0] mem [0:`DBWS_DEPTH-1];

  // only the selected lanes change; no reset so it maps onto block ram
  always_ff @(posedge clk_in) begin
    if (lane_we_in[`DBWS_LANE_HI]) begin
      mem[addr_in][`DBWS_HI_MSB:`DBWS_HI_LSB] <= wdata_in[`DBWS_HI_MSB:`DBWS_HI_LSB];
    end
    if (lane_we_in[`DBWS_LANE_LO]) begin
      mem[addr_in][`DBWS_LO_MSB:`DBWS_LO_LSB] <= wdata_in[`DBWS_LO_MSB:`DBWS_LO_LSB];
    end
  end

  // reads always return the whole word
  always_ff @(posedge clk_in) begin
    if (rd_en_in) begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule

// ---- rtl/dbws_port.sv ----
`timescale 1ns/100ps
`include "dbws_regs.svh"

// Summary of operation
// RULE_01: read versus write and the lanes written come only from the two select lines; the code makes the rmw read half a word read whatever the selects.
// RULE_02: the requestor sets and clears both select lines itself for every operation.
// RULE_03: upper select set writes data bits 8-15 of the addressed word.
// RULE_04: lower select set writes data bits 0-7 of the addressed word.
// RULE_05: both selects set writes all sixteen bits of the addressed word.
// RULE_06: both selects clear means read, and a read always returns the full word; the code's rmw write half with both clear acks and stores nothing.
// RULE_07: cycle-type set selects read-write, clear selects read-modify-write.
// RULE_08: data-ready rises with read data on the lines and also acknowledges every request; the code does not ack write initiate in a read-write cycle.
// RULE_09: the requestor drives a 16-bit word address and 16 two-way data lines.
// RULE_10: the requestor holds the selects stable through an operation.
module dbws_port
  import dbws_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic write_upper_in,
  input wire logic write_lower_in,
  input wire logic read_initiate_in,
  input wire logic write_initiate_in,
  input wire logic full_cycle_in,
  input wire logic [`DBWS_ADDR_W-1:0] addr_in,
  input wire logic [`DBWS_DATA_W-1:0] data_in,
  output logic [`DBWS_DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic data_avail_out
);
  // two-flop synchronisers for every pin
  logic [`DBWS_ADDR_W-1:0] addr_s1_r, addr_s2_r;
  logic [`DBWS_DATA_W-1:0] data_s1_r, data_s2_r;
  logic [`DBWS_CTL_W-1:0] ctl_s1_r, ctl_s2_r;
  logic rd_init_d_r, wr_init_d_r;
  logic upper_s, lower_s, rd_init_s, wr_init_s, full_s;
  logic rd_rise, wr_rise;

  dbws_state_t state_r, state_nxt;
  logic [`DBWS_ADDR_W-1:0] addr_r;
  logic [`DBWS_DATA_W-1:0] wdata_r;
  logic watch_wr_r; // acknowledge held by write initiate (rmw write half)
  logic rmw_r; // current read started a read-modify-write
  logic [`DBWS_DATA_W-1:0] data_out_r;
  logic data_oe_r, data_avail_r;

  logic [1:0] lane_we;
  logic mem_rd;
  logic [`DBWS_DATA_W-1:0] mem_rdata;
  dbws_op_t op_now;
  logic init_held;

  assign data_out = data_out_r;
  assign data_oe_out = data_oe_r;
  assign data_avail_out = data_avail_r;

  // pins arrive from another party's logic, so nothing reads them unsynchronised
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_s1_r <= `DBWS_CTL_RST;
      ctl_s2_r <= `DBWS_CTL_RST;
      addr_s1_r <= `DBWS_ADDR_RST;
      addr_s2_r <= `DBWS_ADDR_RST;
      data_s1_r <= `DBWS_WORD_RST;
      data_s2_r <= `DBWS_WORD_RST;
    end else begin
      ctl_s1_r <= {full_cycle_in, write_initiate_in, read_initiate_in,
                   write_lower_in, write_upper_in};
      ctl_s2_r <= ctl_s1_r;
      addr_s1_r <= addr_in; // [RULE_09]
      addr_s2_r <= addr_s1_r;
      data_s1_r <= data_in;
      data_s2_r <= data_s1_r;
    end
  end

  assign upper_s = ctl_s2_r[`DBWS_CTL_UPPER];
  assign lower_s = ctl_s2_r[`DBWS_CTL_LOWER];
  assign rd_init_s = ctl_s2_r[`DBWS_CTL_RDINIT];
  assign wr_init_s = ctl_s2_r[`DBWS_CTL_WRINIT];
  assign full_s = ctl_s2_r[`DBWS_CTL_FULL];

  // edge detect on the second stage only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_init_d_r <= 1'b0;
      wr_init_d_r <= 1'b0;
    end else begin
      rd_init_d_r <= rd_init_s;
      wr_init_d_r <= wr_init_s;
    end
  end

  assign rd_rise = rd_init_s && !rd_init_d_r;
  assign wr_rise = wr_init_s && !wr_init_d_r;
  // selects are sampled at the initiate edge; stability is the requestor's job
  assign op_now = dbws_decode(upper_s, lower_s); // [RULE_01] [RULE_10]
  assign init_held = watch_wr_r ? wr_init_s : rd_init_s;

  // memory strobes: writes touch only the chosen lanes, reads fetch the word
  always_comb begin
    lane_we = `DBWS_LANES_NONE;
    mem_rd = 1'b0;
    if (state_r == DBWS_ST_IDLE && rd_rise) begin
      if (full_s) begin
        lane_we = dbws_lanes(op_now); // [RULE_03] [RULE_04] [RULE_05] [RULE_07]
        mem_rd = (op_now == DBWS_OP_READ); // [RULE_06]
      end else begin
        mem_rd = 1'b1; // rmw read half is always a word read [RULE_07]
      end
    end else if (state_r == DBWS_ST_RMW_WAIT && wr_rise) begin
      lane_we = dbws_lanes(op_now); // [RULE_03] [RULE_04] [RULE_05]
    end
  end

  // cycle sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DBWS_ST_IDLE: begin
        if (rd_rise) begin
          state_nxt = mem_rd ? DBWS_ST_RD_WAIT : DBWS_ST_ACK;
        end
      end
      DBWS_ST_RD_WAIT: state_nxt = DBWS_ST_ACK;
      DBWS_ST_ACK: begin
        if (!init_held) begin
          state_nxt = (rmw_r && !watch_wr_r) ? DBWS_ST_RMW_WAIT : DBWS_ST_IDLE;
        end
      end
      DBWS_ST_RMW_WAIT: begin
        if (wr_rise) begin
          state_nxt = DBWS_ST_ACK;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= DBWS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request capture; address and data feed the store straight from the second synchroniser stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rmw_r <= 1'b0;
      watch_wr_r <= 1'b0;
    end else if (state_r == DBWS_ST_IDLE && rd_rise) begin
      rmw_r <= !full_s; // [RULE_07]
      watch_wr_r <= 1'b0;
    end else if (state_r == DBWS_ST_RMW_WAIT && wr_rise) begin
      watch_wr_r <= 1'b1;
    end else if (state_r == DBWS_ST_ACK && !init_held && watch_wr_r) begin
      rmw_r <= 1'b0;
      watch_wr_r <= 1'b0;
    end
  end

  always_comb begin
    addr_r = addr_s2_r;
    wdata_r = data_s2_r;
  end

  // acknowledge and read data: up while the initiate line stays set
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_avail_r <= 1'b0;
      data_oe_r <= 1'b0;
      data_out_r <= `DBWS_WORD_RST;
    end else begin
      if (state_r == DBWS_ST_RD_WAIT) begin
        data_out_r <= mem_rdata; // full word always [RULE_06]
        data_oe_r <= 1'b1;
        data_avail_r <= 1'b1; // data on lines [RULE_08]
      end else if ((state_r == DBWS_ST_IDLE && rd_rise && !mem_rd) ||
                   (state_r == DBWS_ST_RMW_WAIT && wr_rise)) begin
        data_avail_r <= 1'b1; // write acknowledge [RULE_08]
        data_oe_r <= 1'b0;
      end else if (state_r == DBWS_ST_ACK && !init_held) begin
        data_avail_r <= 1'b0;
        data_oe_r <= 1'b0;
      end
    end
  end

  dbws_mem u_mem (
    .clk_in(clk_in),
    .addr_in(addr_r),
    .wdata_in(wdata_r),
    .lane_we_in(lane_we),
    .rd_en_in(mem_rd),
    .rdata_out(mem_rdata)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_read_no_lanes: assert property ( // [RULE_06]
    (state_r == DBWS_ST_IDLE && rd_rise && full_s && !upper_s && !lower_s)
      |-> lane_we == 2'h0 && mem_rd)
    else $error("read wrote a lane");
  a_upper_lane_map: assert property ( // [RULE_03]
    lane_we[`DBWS_LANE_HI] |-> upper_s && (state_r == DBWS_ST_RMW_WAIT || full_s))
    else $error("upper lane written without upper select");
  a_lower_lane_map: assert property ( // [RULE_04]
    lane_we[`DBWS_LANE_LO] |-> lower_s && (state_r == DBWS_ST_RMW_WAIT || full_s))
    else $error("lower lane written without lower select");
  a_word_write_all: assert property ( // [RULE_05]
    (state_r == DBWS_ST_IDLE && rd_rise && full_s && upper_s && lower_s)
      |-> lane_we == 2'h3 ##1 data_avail_r && !data_oe_r)
    else $error("word write did not cover both lanes");
  a_read_data_ready: assert property ( // [RULE_08]
    (state_r == DBWS_ST_IDLE && mem_rd) |-> ##2 data_avail_r && data_oe_r &&
      data_out_r == $past(mem_rdata))
    else $error("read data not presented two cycles after start");
  a_oe_needs_ready: assert property ( // [RULE_08]
    data_oe_r |-> data_avail_r)
    else $error("data driven without data ready");
  a_ready_release: assert property ( // [RULE_08]
    (state_r == DBWS_ST_ACK && !init_held) |-> ##1 !data_avail_r && !data_oe_r)
    else $error("acknowledge not dropped after initiate release");
  a_rmw_read_half: assert property ( // [RULE_07]
    (state_r == DBWS_ST_IDLE && rd_rise && !full_s) |-> mem_rd && lane_we == 2'h0
      ##1 state_r == DBWS_ST_RD_WAIT)
    else $error("rmw read half not a word read");
  a_rmw_wait_quiet: assert property ( // [RULE_07]
    (state_r == DBWS_ST_RMW_WAIT && !wr_rise) |-> ##1 !data_avail_r)
    else $error("acknowledge raised while awaiting rmw write");

  c_word_read: cover property (state_r == DBWS_ST_RD_WAIT && !rmw_r);
  c_byte_write: cover property (lane_we == 2'h1 || lane_we == 2'h2);
  c_word_write: cover property (lane_we == 2'h3);
  c_rmw_write: cover property (state_r == DBWS_ST_RMW_WAIT && wr_rise);
endmodule

// ---- shared/dbws_pkg.sv ----
package dbws_pkg;

  typedef enum logic [1:0] {
    DBWS_OP_READ,
    DBWS_OP_WR_LOWER,
    DBWS_OP_WR_UPPER,
    DBWS_OP_WR_WORD
  } dbws_op_t;

  typedef enum {
    DBWS_ST_IDLE,
    DBWS_ST_RD_WAIT,
    DBWS_ST_ACK,
    DBWS_ST_RMW_WAIT
  } dbws_state_t;

  // operation from the two byte-write select lines only
  function automatic dbws_op_t dbws_decode(input logic upper, input logic lower);
    dbws_op_t op;
    op = DBWS_OP_READ;
    if (upper && lower) begin
      op = DBWS_OP_WR_WORD;
    end else if (upper) begin
      op = DBWS_OP_WR_UPPER;
    end else if (lower) begin
      op = DBWS_OP_WR_LOWER;
    end
    return op;
  endfunction

  // lane enables {upper, lower} for an operation
  function automatic logic [1:0] dbws_lanes(input dbws_op_t op);
    logic [1:0] l;
    l = 2'h0;
    unique case (op)
      DBWS_OP_READ: l = 2'h0;
      DBWS_OP_WR_LOWER: l = 2'h1;
      DBWS_OP_WR_UPPER: l = 2'h2;
      DBWS_OP_WR_WORD: l = 2'h3;
    endcase
    return l;
  endfunction

endpackage

// ---- shared/dbws_regs.svh ----
`ifndef DBWS_REGS_SVH
`define DBWS_REGS_SVH

// port widths
`define DBWS_ADDR_W 16
`define DBWS_DATA_W 16
`define DBWS_DEPTH 65536

// byte lanes of the data word
`define DBWS_LO_LSB 0
`define DBWS_LO_MSB 7
`define DBWS_HI_LSB 8
`define DBWS_HI_MSB 15

// lane enable bit positions
`define DBWS_LANE_LO 0
`define DBWS_LANE_HI 1

// control synchroniser fields, one bit per requestor line
`define DBWS_CTL_W 5
`define DBWS_CTL_UPPER 0
`define DBWS_CTL_LOWER 1
`define DBWS_CTL_RDINIT 2
`define DBWS_CTL_WRINIT 3
`define DBWS_CTL_FULL 4
`define DBWS_CTL_RST 5'h00

// reset values
`define DBWS_WORD_RST 16'h0000
`define DBWS_ADDR_RST 16'h0000
`define DBWS_LANES_NONE 2'h0

`endif
